// ### core/tcpwm_cfg.svh
`ifndef TCPWM_CFG_SVH
`define TCPWM_CFG_SVH

// Register indexes; the byte address is four times the index.
`define TCPWM_IDX_TSC 8'h40
`define TCPWM_IDX_CNTH 8'h41
`define TCPWM_IDX_CNTL 8'h42
`define TCPWM_IDX_MODH 8'h43
`define TCPWM_IDX_MODL 8'h44
`define TCPWM_IDX_SC0 8'h45
`define TCPWM_IDX_CH0H 8'h46
`define TCPWM_IDX_CH0L 8'h47
`define TCPWM_IDX_SC1 8'h48
`define TCPWM_IDX_CH1H 8'h49
`define TCPWM_IDX_CH1L 8'h4A
`define TCPWM_IDX_BFCR 8'h4B

// Bit positions in the timer control/status register.
`define TCPWM_TSC_FLAG 7
`define TCPWM_TSC_IE 6
`define TCPWM_TSC_HALT 5
`define TCPWM_TSC_TRST 4
// Bit positions in the channel control/status registers and flag control.
`define TCPWM_SC_FLAG 7
`define TCPWM_BFCR_CLR_EN 7

// Reset values and codes.
`define TCPWM_MOD_RST 16'hFFFF
`define TCPWM_PS_EXT 3'h7
`define TCPWM_RESP_OKAY 2'h0
`define TCPWM_RESP_SLVERR 2'h2

`endif

// ### core/tcpwm_pkg.sv
package tcpwm_pkg;

	// Requests from the AXI4-Lite master.
	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} tcpwm_axi_req_t;

	// Answers of the AXI4-Lite slave.
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tcpwm_axi_rsp_t;

	// One channel: control byte in register bit order, then its value.
	typedef struct packed {
		logic flag;
		logic ie;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
		logic tov;
		logic max;
		logic [15:0] val;
	} tcpwm_chan_t;

	// Whole state of the core.
	typedef struct packed {
		tcpwm_axi_rsp_t rsp;
		logic [11:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic wrap_flag;
		logic wrap_irq_enable;
		logic halt;
		logic [2:0] ps;
		logic [15:0] cnt;
		logic [15:0] modv;
		logic [7:0] lo_latch;
		logic latched;
		logic mod_inhibit;
		tcpwm_chan_t [1:0] ch;
		logic [2:0] armed;
		logic break_flag_clear_enable;
		logic act_sel;
		logic next_sel;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic irq;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
	} tcpwm_state_t;

	// State of the prescaler.
	typedef struct packed {
		logic [5:0] div;
	} tcpwm_psc_state_t;

endpackage

// ### core/tcpwm_prescaler.sv
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"

module tcpwm_prescaler import tcpwm_pkg::*; (
	input wire logic clk, // Bus clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic clear, // Clears the divider.
	input wire logic run, // Counting allowed.
	input wire logic [2:0] ps, // Prescale select.
	input wire logic ext_rise, // Synchronised rising edge of the external clock.
	output logic tick // One-cycle counter clock enable.
);

	tcpwm_psc_state_t st;
	tcpwm_psc_state_t n;
	logic [5:0] mask;

	// Divider and tick selection; code seven takes the external pin instead.
	always_comb begin
		n = st;
		mask = 6'((7'h01 << ps) - 7'h01);
		if (clear) begin
			n.div = 6'h00;
		end else if (run) begin
			n.div = st.div + 6'h01;
		end
		if (!run || clear) begin
			tick = 1'b0;
		end else if (ps == `TCPWM_PS_EXT) begin
			tick = ext_rise; // R23
		end else begin
			tick = ((st.div & mask) == mask); // R23
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

endmodule

// ### core/tcpwm_core.sv
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"

// Contract
// [R1] With toggle-on-wrap set, the output inverts at every counter wrap.
// [R2] Pulse width runs from wrap to compare; compare clears or sets output.
// [R3] Prescale one and wrap value 255 give a 256-clock period.
// [R4] Compare value 128 with an 8-bit period gives half duty.
// [R5] Unbuffered value writes act at once; a missed compare may follow.
// [R6] Software writes shorter widths at compare, longer widths at wrap.
// [R7] Compare flag rises at pulse end, wrap flag at period end.
// [R8] Software avoids toggle-on-compare for PWM channels.
// [R9] Buffered select links both channels onto the channel 0 pin.
// [R10] In buffered mode the last written channel controls from next wrap.
// [R11] Buffered mode: channel 0 control governs, channel 1 pin is released.
// [R12] Software never writes the active channel in buffered mode.
// [R13] Software follows the halt, clear, program, release start-up order.
// [R14] Buffered select wins over the single mode bit.
// [R15] Toggle-on-wrap clear means no wrap toggle, giving zero duty.
// [R16] Full-duty and toggle-on-wrap together give a constant active output.
// [R17] Wrap sets the wrap flag; enabled, it requests an interrupt.
// [R18] Capture or compare sets the channel flag; enabled, it interrupts.
// [R19] In wait mode the timer runs, registers are closed, interrupts wake.
// [R20] In stop mode the timer freezes and keeps all its state.
// [R21] A debug break halts the counter and suppresses captures.
// [R22] During break, flags clear only with the break clear enable set.
// [R23] Prescale codes divide by 1 to 64; code seven uses the pin.
// [R24] Flags clear by read then write 0; new events and 1s win.
// [R25] At the wrap value the counter restarts from zero next tick.
module tcpwm_core import tcpwm_pkg::*; (
	input wire logic clk, // Bus clock, 50 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input tcpwm_axi_req_t axi_req, // AXI4-Lite requests.
	output tcpwm_axi_rsp_t axi_rsp, // AXI4-Lite answers.
	input wire logic wait_mode, // CPU in wait mode.
	input wire logic stop_mode, // CPU in stop mode.
	input wire logic debug_break, // Debug break state.
	input wire logic channel0_pin_in, // Channel 0 pin level.
	input wire logic channel1_pin_in, // Channel 1 pin level.
	input wire logic external_count_clock_pin, // External counter clock.
	output logic channel0_pin_out, // Channel 0 pin drive level.
	output logic channel0_pin_oe, // Channel 0 pin driven.
	output logic channel1_pin_out, // Channel 1 pin drive level.
	output logic channel1_pin_oe, // Channel 1 pin driven.
	output logic irq // Interrupt and wake request.
);

	tcpwm_state_t st;
	tcpwm_state_t n;
	logic tick;
	logic run;
	logic psc_clear;
	logic wrap;
	logic wr_fire;
	logic ar_fire;
	logic we;
	logic wok;
	logic rok;
	logic clr_ok;
	logic bufm;
	logic [7:0] widx;
	logic [7:0] ridx;
	logic [7:0] wv;
	logic [7:0] rbyte;
	logic [2:0] sets;
	logic [2:0] clrs;
	logic [2:0] wflag;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] oc_v;
	logic [1:0] ic_v;
	logic [15:0] cmp_v [2];
	logic [1:0] outv;
	logic [1:0] hit;
	logic [15:0] cnt_step;

	// True for an aligned address inside the register map.
	function automatic logic addr_ok(input logic [11:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(idx >= `TCPWM_IDX_TSC) && (idx <= `TCPWM_IDX_BFCR);
	endfunction

	// A hardware set beats a clear in the same cycle.
	function automatic logic flag_next(input logic f, input logic s, input logic c);
		return s | (f & ~c);
	endfunction

	// Control byte of a channel, flag in bit 7.
	function automatic logic [7:0] ctrl_byte(input tcpwm_chan_t c);
		return {c.flag, c.ie, c.msb, c.msa, c.elsb, c.elsa, c.tov, c.max};
	endfunction

	tcpwm_prescaler u_psc (
		.clk(clk),
		.reset_n(reset_n),
		.clear(psc_clear),
		.run(run),
		.ps(st.ps),
		.ext_rise(st.s2[2] & ~st.s3[2]),
		.tick(tick)
	);

	// Read data multiplexer.
	always_comb begin
		case (ridx)
			`TCPWM_IDX_TSC: rbyte = {st.wrap_flag, st.wrap_irq_enable, st.halt, 2'b00, st.ps};
			`TCPWM_IDX_CNTH: rbyte = st.cnt[15:8];
			`TCPWM_IDX_CNTL: rbyte = st.latched ? st.lo_latch : st.cnt[7:0];
			`TCPWM_IDX_MODH: rbyte = st.modv[15:8];
			`TCPWM_IDX_MODL: rbyte = st.modv[7:0];
			`TCPWM_IDX_SC0: rbyte = ctrl_byte(st.ch[0]);
			`TCPWM_IDX_CH0H: rbyte = st.ch[0].val[15:8];
			`TCPWM_IDX_CH0L: rbyte = st.ch[0].val[7:0];
			`TCPWM_IDX_SC1: rbyte = ctrl_byte(st.ch[1]);
			`TCPWM_IDX_CH1H: rbyte = st.ch[1].val[15:8];
			`TCPWM_IDX_CH1L: rbyte = st.ch[1].val[7:0];
			`TCPWM_IDX_BFCR: rbyte = {st.break_flag_clear_enable, 7'h00};
			default: rbyte = 8'h00;
		endcase
	end

	// Next-state logic for bus, registers, counter and channels.
	always_comb begin
		n = st;
		outv = '0;
		n.s1 = {external_count_clock_pin, channel1_pin_in, channel0_pin_in};
		n.s2 = st.s1;
		n.s3 = st.s2;
		rise = st.s2[1:0] & ~st.s3[1:0];
		fall = ~st.s2[1:0] & st.s3[1:0];
		run = ~st.halt & ~stop_mode & ~debug_break; // R20 R21
		clr_ok = ~debug_break | st.break_flag_clear_enable; // R22
		bufm = st.ch[0].msb; // R14
		sets = 3'b000;
		clrs = 3'b000;
		wflag = 3'b000;
		oc_v = 2'b00;
		ic_v = 2'b00;

		// Write channel: address and data are taken in either order.
		if (axi_req.awvalid && st.rsp.awready) begin
			n.waddr = axi_req.awaddr;
			n.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && st.rsp.wready) begin
			n.wdata = axi_req.wdata[7:0];
			n.wstrb0 = axi_req.wstrb[0];
			n.rsp.wready = 1'b0;
		end
		wr_fire = ~st.rsp.awready & ~st.rsp.wready & ~st.rsp.bvalid;
		widx = st.waddr[9:2];
		wv = st.wdata;
		wok = addr_ok(st.waddr) & ~wait_mode; // R19
		we = wr_fire & wok & st.wstrb0;
		if (wr_fire) begin
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = wok ? `TCPWM_RESP_OKAY : `TCPWM_RESP_SLVERR;
		end
		if (st.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
			n.rsp.awready = 1'b1;
			n.rsp.wready = 1'b1;
		end

		// Read channel: one cycle from address to data.
		ar_fire = axi_req.arvalid & st.rsp.arready;
		ridx = axi_req.araddr[9:2];
		rok = addr_ok(axi_req.araddr) & ~wait_mode; // R19
		if (ar_fire) begin
			n.rsp.arready = 1'b0;
			n.rsp.rvalid = 1'b1;
			n.rsp.rresp = rok ? `TCPWM_RESP_OKAY : `TCPWM_RESP_SLVERR;
			n.rsp.rdata = rok ? {24'h000000, rbyte} : 32'h00000000;
		end
		if (st.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
			n.rsp.arready = 1'b1;
		end

		// Register writes; flags only record a clear request here.
		psc_clear = we && (widx == `TCPWM_IDX_TSC) && wv[`TCPWM_TSC_TRST];
		if (we) begin
			case (widx)
				`TCPWM_IDX_TSC: begin
					n.wrap_irq_enable = wv[`TCPWM_TSC_IE];
					n.halt = wv[`TCPWM_TSC_HALT];
					n.ps = wv[2:0];
					wflag[0] = 1'b1;
				end
				`TCPWM_IDX_MODH: begin
					n.modv[15:8] = wv;
					n.mod_inhibit = 1'b1;
				end
				`TCPWM_IDX_MODL: begin
					n.modv[7:0] = wv;
					n.mod_inhibit = 1'b0;
				end
				`TCPWM_IDX_SC0: begin
					{n.ch[0].ie, n.ch[0].msb, n.ch[0].msa} = wv[6:4];
					{n.ch[0].elsb, n.ch[0].elsa, n.ch[0].tov, n.ch[0].max} = wv[3:0];
					wflag[1] = 1'b1;
				end
				`TCPWM_IDX_CH0H: n.ch[0].val[15:8] = wv; // R5
				`TCPWM_IDX_CH0L: n.ch[0].val[7:0] = wv; // R5
				`TCPWM_IDX_SC1: begin
					if (!bufm) begin // R11
						n.ch[1].ie = wv[6];
						n.ch[1].msa = wv[4];
						{n.ch[1].elsb, n.ch[1].elsa, n.ch[1].tov, n.ch[1].max} = wv[3:0];
						wflag[2] = 1'b1;
					end
				end
				`TCPWM_IDX_CH1H: n.ch[1].val[15:8] = wv; // R5
				`TCPWM_IDX_CH1L: n.ch[1].val[7:0] = wv; // R5
				`TCPWM_IDX_BFCR: n.break_flag_clear_enable = wv[`TCPWM_BFCR_CLR_EN];
				default: n.break_flag_clear_enable = st.break_flag_clear_enable;
			endcase
		end

		// The last written channel pair takes over at the next wrap.
		if (we && bufm && (widx == `TCPWM_IDX_CH1H || widx == `TCPWM_IDX_CH1L)) begin
			n.next_sel = 1'b1; // R10
		end
		if (we && bufm && (widx == `TCPWM_IDX_CH0H || widx == `TCPWM_IDX_CH0L)) begin
			n.next_sel = 1'b0; // R10
		end

		// Clear request: write 0 after an armed read, unless a break protects it.
		for (int k = 0; k < 3; k++) begin
			clrs[k] = wflag[k] & ~wv[`TCPWM_SC_FLAG] & st.armed[k] & clr_ok; // R24 R22
			if (wflag[k] && clr_ok) begin
				n.armed[k] = 1'b0;
			end
		end

		// Reads arm the clear and latch the counter's low byte.
		if (ar_fire && rok) begin
			if (clr_ok && ridx == `TCPWM_IDX_TSC && st.wrap_flag) begin
				n.armed[0] = 1'b1; // R24
			end
			if (clr_ok && ridx == `TCPWM_IDX_SC0 && st.ch[0].flag) begin
				n.armed[1] = 1'b1; // R24
			end
			if (clr_ok && ridx == `TCPWM_IDX_SC1 && st.ch[1].flag) begin
				n.armed[2] = 1'b1; // R24
			end
			if (ridx == `TCPWM_IDX_CNTH && !st.latched) begin
				n.lo_latch = st.cnt[7:0];
				n.latched = 1'b1;
			end
			if (ridx == `TCPWM_IDX_CNTL) begin
				n.latched = 1'b0;
			end
		end

		// Free-running counter with wrap at the programmed value.
		wrap = tick && (st.cnt == st.modv); // R3
		cnt_step = wrap ? 16'h0000 : st.cnt + 16'h0001; // Count that this tick moves to.
		if (psc_clear) begin
			n.cnt = 16'h0000;
		end else if (wrap) begin
			n.cnt = 16'h0000; // R25
		end else if (tick) begin
			n.cnt = st.cnt + 16'h0001;
		end
		sets[0] = wrap & ~psc_clear & ~st.mod_inhibit; // R17 R7
		if (!bufm) begin
			n.act_sel = 1'b0;
			n.next_sel = 1'b0;
		end else if (wrap) begin
			n.act_sel = n.next_sel; // R9 R10
		end

		// Output compare, PWM and input capture per channel.
		for (int i = 0; i < 2; i++) begin
			if (i == 0) begin
				oc_v[i] = st.ch[0].msb | st.ch[0].msa; // R14
			end else begin
				oc_v[i] = st.ch[1].msa & ~bufm; // R11
			end
			ic_v[i] = ~st.ch[i].msb & ~st.ch[i].msa & ~(i == 1 && bufm);
			cmp_v[i] = (i == 0 && bufm && st.act_sel) ? st.ch[1].val : st.ch[i].val;
			outv[i] = st.pin_out[i];
			// The compare acts on the tick that brings the counter to the channel value,
			// so a pulse lasts exactly that many counts after the wrap.
			hit[i] = oc_v[i] & tick & (cnt_step == cmp_v[i]); // R2 R4
			if (hit[i]) begin
				sets[i + 1] = 1'b1; // R7 R18
				case ({st.ch[i].elsb, st.ch[i].elsa})
					2'b01: outv[i] = ~st.pin_out[i];
					2'b10: outv[i] = 1'b0; // R2 R4
					2'b11: outv[i] = 1'b1; // R2
					default: outv[i] = st.pin_out[i];
				endcase
			end
			if (oc_v[i] && wrap && st.ch[i].tov) begin
				outv[i] = ~outv[i]; // R1 R15
			end
			if (oc_v[i] && st.ch[i].tov && st.ch[i].max) begin
				outv[i] = 1'b1; // R16
			end
			if (oc_v[i]) begin
				n.pin_out[i] = outv[i];
			end
			n.pin_oe[i] = oc_v[i] & (st.ch[i].elsb | st.ch[i].elsa); // R11
			if (ic_v[i] && run && ((st.ch[i].elsa && rise[i]) || (st.ch[i].elsb && fall[i]))) begin
				n.ch[i].val = st.cnt; // R21
				sets[i + 1] = 1'b1; // R18
			end
		end

		// Flags: a new event disarms the clear and always wins.
		n.wrap_flag = flag_next(st.wrap_flag, sets[0], clrs[0]); // R24
		n.ch[0].flag = flag_next(st.ch[0].flag, sets[1], clrs[1]); // R24
		n.ch[1].flag = flag_next(st.ch[1].flag, sets[2], clrs[2]); // R24
		for (int k = 0; k < 3; k++) begin
			if (sets[k]) begin
				n.armed[k] = 1'b0; // R24
			end
		end
		n.irq = (n.wrap_flag & n.wrap_irq_enable) | (n.ch[0].flag & n.ch[0].ie) |
			(n.ch[1].flag & n.ch[1].ie & ~bufm); // R17 R18 R19
	end

	// State register; the counter starts halted and the wrap value at its top.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
			st.rsp.awready <= 1'b1;
			st.rsp.wready <= 1'b1;
			st.rsp.arready <= 1'b1;
			st.halt <= 1'b1;
			st.modv <= `TCPWM_MOD_RST;
		end else begin
			st <= n;
		end
	end

	// Outputs straight from the state register.
	assign axi_rsp = st.rsp;
	assign channel0_pin_out = st.pin_out[0];
	assign channel0_pin_oe = st.pin_oe[0];
	assign channel1_pin_out = st.pin_out[1];
	assign channel1_pin_oe = st.pin_oe[1];
	assign irq = st.irq;

	// Checks on the counter, channel outputs and flags.
	property p_wrap_zero;
		@(posedge clk) disable iff (!reset_n)
		wrap && !psc_clear && !st.mod_inhibit |=> st.cnt == 16'h0000 && st.wrap_flag;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("no restart at wrap"); // R3 R17 R25

	property p_wrap_toggle;
		@(posedge clk) disable iff (!reset_n)
		wrap && oc_v[0] && st.ch[0].tov && !st.ch[0].max && !hit[0]
		|=> channel0_pin_out != $past(channel0_pin_out);
	endproperty
	a_wrap_toggle: assert property (p_wrap_toggle) else $error("no toggle at wrap"); // R1

	property p_cmp_clear;
		@(posedge clk) disable iff (!reset_n)
		hit[0] && {st.ch[0].elsb, st.ch[0].elsa} == 2'b10
		&& !st.ch[0].tov ##1 1'b1 |-> !channel0_pin_out ##1 1'b1;
	endproperty
	a_cmp_clear: assert property (p_cmp_clear) else $error("compare did not clear"); // R2 R15

	property p_cmp_flag;
		@(posedge clk) disable iff (!reset_n)
		hit[0] |=> st.ch[0].flag ##1 irq || !st.ch[0].ie;
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missing"); // R7 R18

	property p_div1;
		@(posedge clk) disable iff (!reset_n)
		run && st.ps == 3'h0 && !psc_clear |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide-by-one tick missing"); // R3 R23

	property p_full;
		@(posedge clk) disable iff (!reset_n)
		oc_v[0] && st.ch[0].tov && st.ch[0].max |=> channel0_pin_out;
	endproperty
	a_full: assert property (p_full) else $error("full duty not held"); // R16

	property p_ch1_free;
		@(posedge clk) disable iff (!reset_n)
		bufm |=> !channel1_pin_oe;
	endproperty
	a_ch1_free: assert property (p_ch1_free) else $error("channel 1 pin still driven"); // R11

	property p_sel_hold;
		@(posedge clk) disable iff (!reset_n)
		bufm && !wrap && $past(bufm) |=> $stable(st.act_sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("channel switch off wrap"); // R10

	property p_freeze;
		@(posedge clk) disable iff (!reset_n)
		(stop_mode || debug_break) && !psc_clear |=> $stable(st.cnt);
	endproperty
	a_freeze: assert property (p_freeze) else $error("counter moved while frozen"); // R20 R21

	property p_brk_flag;
		@(posedge clk) disable iff (!reset_n)
		debug_break && !st.break_flag_clear_enable && st.wrap_flag |=> st.wrap_flag;
	endproperty
	a_brk_flag: assert property (p_brk_flag) else $error("flag cleared in break"); // R22

	property p_wr_one;
		@(posedge clk) disable iff (!reset_n)
		we && widx == `TCPWM_IDX_TSC && wv[`TCPWM_SC_FLAG] && st.wrap_flag |=> st.wrap_flag;
	endproperty
	a_wr_one: assert property (p_wr_one) else $error("write of one cleared flag"); // R24

endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"

module testbench import tcpwm_pkg::*; ;
	logic clk = 1'b0;
	logic reset_n, wait_mode, stop_mode, debug_break, ext_pin, ext_run, cap_pin;
	logic p0, p0_oe, p1, p1_oe, irq;
	tcpwm_axi_req_t req;
	tcpwm_axi_rsp_t rsp;
	logic [31:0] rd_data;
	logic [1:0] rd_resp, last_bresp;
	logic [15:0] c1, c2;
	int n_fail, samples_checked, seed, ext_div, k, v, pw;

	// Bus clock of 50 MHz.
	always #10 clk = ~clk;

	// External count clock with a period of six bus clocks.
	always @(posedge clk) begin
		if (ext_run) begin
			ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
			if (ext_div == 2) ext_pin <= ~ext_pin;
		end
	end

	tcpwm_core i_tcpwm_core (
		.clk(clk),
		.reset_n(reset_n),
		.axi_req(req),
		.axi_rsp(rsp),
		.wait_mode(wait_mode),
		.stop_mode(stop_mode),
		.debug_break(debug_break),
		.channel0_pin_in(cap_pin),
		.channel1_pin_in(cap_pin),
		.external_count_clock_pin(ext_pin),
		.channel0_pin_out(p0),
		.channel0_pin_oe(p0_oe),
		.channel1_pin_out(p1),
		.channel1_pin_oe(p1_oe),
		.irq(irq)
	);

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compares a register or flag result.
	task automatic check_val(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares a cycle count taken on the pins.
	task automatic check_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			n_fail++;
			$display("unexpected count at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One AXI4-Lite write; address and data are offered together.
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		int n;
		logic done;
		done = 1'b0;
		@(posedge clk);
		req.awaddr <= {idx, 2'b00};
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 100 && !done; n++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				last_bresp = rsp.bresp;
				req.bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_fail++;
			end_of_test();
		end
	endtask

	// One AXI4-Lite read; data and response are taken with rvalid.
	task automatic rd(input logic [9:0] idx);
		int n;
		logic done;
		done = 1'b0;
		@(posedge clk);
		req.araddr <= {idx, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 100 && !done; n++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				rd_data = rsp.rdata;
				rd_resp = rsp.rresp;
				req.rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_fail++;
			end_of_test();
		end
	endtask

	// Reads a register and compares response and masked byte; upper bits must be zero.
	task automatic rd_chk(input logic [9:0] idx, input logic [1:0] er, input logic [7:0] m,
			input logic [7:0] ev);
		rd(idx);
		check_val({6'h00, rd_resp, rd_data & {24'hFFFFFF, m}}, {6'h00, er, 24'h000000, ev});
	endtask

	// Reads the counter, high byte first so the low byte is latched.
	task automatic rd_cnt(output logic [15:0] c);
		rd(`TCPWM_IDX_CNTH);
		c[15:8] = rd_data[7:0];
		rd(`TCPWM_IDX_CNTL);
		c[7:0] = rd_data[7:0];
	endtask

	// Start-up order: halt and clear, program period and width, set mode, release.
	task automatic pwm_setup(input logic [2:0] ps, input logic [15:0] m, input logic [7:0] sc,
			input logic [15:0] w);
		wr(`TCPWM_IDX_TSC, 8'h30);
		wr(`TCPWM_IDX_MODH, m[15:8]);
		wr(`TCPWM_IDX_MODL, m[7:0]);
		wr(`TCPWM_IDX_CH0H, w[15:8]);
		wr(`TCPWM_IDX_CH0L, w[7:0]);
		wr(`TCPWM_IDX_SC0, sc);
		wr(`TCPWM_IDX_TSC, {5'h00, ps});
	endtask

	// Waits until the channel 0 pin moves to the given level; a fall marks the compare
	// and a rise the wrap, where software rewrites a shorter or a longer width.
	task automatic wait_edge(input logic lvl);
		int n;
		for (n = 0; n < 1000 && p0 !== ~lvl; n++) @(posedge clk);
		for (n = 0; n < 1000 && p0 !== lvl; n++) @(posedge clk);
		if (p0 !== lvl) begin
			n_fail++;
			end_of_test();
		end
	endtask

	// Counts high cycles, rising edges and drive enables over a window of whole periods.
	task automatic measure(input int settle, input int win, input int ehi, input int erise,
			input int eoe1);
		int hi, rise, oe0, oe1;
		logic prev;
		hi = 0;
		rise = 0;
		oe0 = 0;
		oe1 = 0;
		repeat (settle) @(posedge clk);
		prev = p0;
		repeat (win) begin
			@(posedge clk);
			if (p0 === 1'b1) hi++;
			if (p0 === 1'b1 && prev === 1'b0) rise++;
			if (p0_oe === 1'b1) oe0++;
			if (p1_oe === 1'b1) oe1++;
			prev = p0;
		end
		check_cnt(hi, ehi);
		check_cnt(rise, erise);
		check_cnt(oe0, win);
		if (eoe1 >= 0) check_cnt(oe1, eoe1);
	endtask

	// Main sequence.
	initial begin
		req = '0;
		reset_n = 1'b0;
		wait_mode = 1'b0;
		stop_mode = 1'b0;
		debug_break = 1'b0;
		ext_pin = 1'b0;
		ext_run = 1'b0;
		cap_pin = 1'b0;
		ext_div = 0;
		n_fail = 0;
		samples_checked = 0;
		seed = 32'h005B8E60;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(`TCPWM_IDX_TSC, 2'h0, 8'hFF, 8'h20);
		rd_chk(`TCPWM_IDX_MODH, 2'h0, 8'hFF, 8'hFF);
		rd_chk(`TCPWM_IDX_MODL, 2'h0, 8'hFF, 8'hFF);
		rd_chk(10'h010, `TCPWM_RESP_SLVERR, 8'hFF, 8'h00);
		pwm_setup(3'h0, 16'h00FF, 8'h5A, 16'h0080);
		measure(300, 512, 256, 2, -1);
		// Random widths written while running: shorter after the compare, longer after the wrap.
		pw = 128;
		for (k = 0; k < 3; k++) begin
			v = $random(seed) & 255;
			if (v < 1) v = 1;
			if (v > 254) v = 254;
			wait_edge(v < pw ? 1'b0 : 1'b1);
			wr(`TCPWM_IDX_CH0L, v[7:0]);
			pw = v;
			measure(600, 512, 2 * v, 2, -1);
		end
		wr(`TCPWM_IDX_TSC, 8'h40);
		repeat (300) @(posedge clk);
		check_val(irq, 40'h1);
		debug_break <= 1'b1;
		rd_cnt(c1);
		repeat (20) @(posedge clk);
		rd_cnt(c2);
		check_val(c2, c1);
		debug_break <= 1'b0;
		stop_mode <= 1'b1;
		rd_cnt(c1);
		repeat (20) @(posedge clk);
		rd_cnt(c2);
		check_val(c2, c1);
		stop_mode <= 1'b0;
		repeat (20) @(posedge clk);
		rd_cnt(c2);
		check_val(c2 !== c1, 40'h1);
		wait_mode <= 1'b1;
		rd_chk(`TCPWM_IDX_TSC, `TCPWM_RESP_SLVERR, 8'hFF, 8'h00);
		wr(`TCPWM_IDX_TSC, 8'h60);
		check_val({last_bresp, irq}, {`TCPWM_RESP_SLVERR, 1'b1});
		wait_mode <= 1'b0;
		// Flag clearing: unarmed write, arming read, a write during a break, final clear.
		wr(`TCPWM_IDX_TSC, 8'h60);
		rd_chk(`TCPWM_IDX_TSC, 2'h0, 8'hFF, 8'hE0);
		debug_break <= 1'b1;
		wr(`TCPWM_IDX_TSC, 8'h60);
		rd_chk(`TCPWM_IDX_TSC, 2'h0, 8'hFF, 8'hE0);
		debug_break <= 1'b0;
		wr(`TCPWM_IDX_TSC, 8'h60);
		rd_chk(`TCPWM_IDX_TSC, 2'h0, 8'hFF, 8'h60);
		rd_chk(`TCPWM_IDX_SC0, 2'h0, 8'hFF, 8'hDA);
		wr(`TCPWM_IDX_SC0, 8'hDA);
		rd_chk(`TCPWM_IDX_SC0, 2'h0, 8'hFF, 8'hDA);
		wr(`TCPWM_IDX_SC0, 8'h5A);
		rd_chk(`TCPWM_IDX_SC0, 2'h0, 8'hFF, 8'h5A);
		@(posedge clk);
		check_val(irq, 40'h0);
		pwm_setup(3'h0, 16'h00FF, 8'h18, 16'h0080);
		measure(600, 512, 0, 0, -1);
		pwm_setup(3'h0, 16'h00FF, 8'h1B, 16'h0080);
		measure(600, 512, 512, 0, -1);
		// Every divided prescale code on a 16-count period, then the external clock.
		for (k = 1; k < 7; k++) begin
			pwm_setup(k[2:0], 16'h000F, 8'h1A, 16'h0008);
			measure((16 << k) + 40, 32 << k, 16 << k, 2, -1);
		end
		// Rising-edge capture on channel 1 with the counter parked, then one inside a break.
		wr(`TCPWM_IDX_TSC, {5'h00, `TCPWM_PS_EXT});
		wr(`TCPWM_IDX_SC1, 8'h04);
		rd_cnt(c1);
		cap_pin <= 1'b1;
		repeat (5) @(posedge clk);
		rd_chk(`TCPWM_IDX_CH1H, 2'h0, 8'hFF, c1[15:8]);
		rd_chk(`TCPWM_IDX_CH1L, 2'h0, 8'hFF, c1[7:0]);
		rd_chk(`TCPWM_IDX_SC1, 2'h0, 8'hFF, 8'h84);
		cap_pin <= 1'b0;
		wr(`TCPWM_IDX_SC1, 8'h04);
		debug_break <= 1'b1;
		cap_pin <= 1'b1;
		repeat (5) @(posedge clk);
		debug_break <= 1'b0;
		rd_chk(`TCPWM_IDX_SC1, 2'h0, 8'hFF, 8'h04);
		// Channel 1 drives its own pin while the channels are not linked.
		wr(`TCPWM_IDX_SC1, 8'h1A);
		ext_run <= 1'b1;
		pwm_setup(`TCPWM_PS_EXT, 16'h000F, 8'h1A, 16'h0008);
		measure(150, 192, 96, 2, 192);
		ext_run <= 1'b0;
		// Buffered operation: channel 0 first, then whichever pair was written last.
		pwm_setup(3'h0, 16'h00FF, 8'h2A, 16'h0040);
		measure(300, 512, 128, 2, 0);
		wr(`TCPWM_IDX_CH1H, 8'h00);
		wr(`TCPWM_IDX_CH1L, 8'hC0);
		measure(600, 512, 384, 2, 0);
		wr(`TCPWM_IDX_CH0L, 8'h20);
		measure(600, 512, 64, 2, 0);
		wr(`TCPWM_IDX_SC0, 8'h3A);
		measure(600, 512, 64, 2, 0);
		end_of_test();
	end
endmodule
